// ===== pbs_sram_port.sv
// Pipelined burst SRAM port: control pipeline, burst counter, storage and data bus
`timescale 1ns/1ps
module pbs_sram_port
	import pbs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Address and control
	input wire logic [PBS_ADDR_W-1:0] address,
	input wire logic advance_load_select,
	input wire logic rw_select,
	input wire logic [PBS_LANES-1:0] byte_write_enables_n,
	input wire logic burst_order_select,
	input wire logic chip_select_low_a_n,
	input wire logic chip_select_low_b_n,
	input wire logic chip_select_pair,
	input wire logic clock_enable_n,
	// Data bus, split into its three signals
	input wire logic [PBS_DATA_W-1:0] data_in,
	output logic [PBS_DATA_W-1:0] data_out,
	output logic data_oe_n
);

	// ****************************************
	// State
	// ****************************************
	logic [PBS_DATA_W-1:0] mem_reg [0:PBS_DEPTH-1];
	logic burst_reg, burst_next;
	logic burst_wr_reg, burst_wr_next;
	pbs_order_e order_reg, order_next;
	logic [PBS_ADDR_W-1:0] base_reg, base_next;
	logic [PBS_BURST_W-1:0] cnt_reg, cnt_next;
	logic s1_valid_reg, s1_valid_next;
	logic s1_wr_reg, s1_wr_next;
	logic [PBS_ADDR_W-1:0] s1_addr_reg, s1_addr_next;
	logic [PBS_LANES-1:0] s1_bw_reg, s1_bw_next;
	logic s2_valid_reg, s2_valid_next;
	logic s2_wr_reg, s2_wr_next;
	logic [PBS_ADDR_W-1:0] s2_addr_reg, s2_addr_next;
	logic [PBS_LANES-1:0] s2_bw_reg, s2_bw_next;
	logic [PBS_DATA_W-1:0] dout_reg, dout_next;
	logic oe_n_reg, oe_n_next;
	logic [PBS_DATA_W-1:0] wdata;
	logic active, selected, mem_we;
	logic [PBS_BURST_W-1:0] beat_cnt, beat_low;

	// Clock enable gates every register; selection needs all three enables
	assign active = ~clock_enable_n;
	assign selected = ~chip_select_low_a_n & ~chip_select_low_b_n & chip_select_pair;

	// Next beat offset in the chosen order
	always_comb
	begin
		beat_cnt = cnt_reg + PBS_CNT_STEP;
		if (order_reg == PBS_INTERLEAVED)
			beat_low = base_reg[PBS_BURST_W-1:0] ^ beat_cnt;
		else
			beat_low = base_reg[PBS_BURST_W-1:0] + beat_cnt;
	end

	// ****************************************
	// Address stage and burst counter
	// ****************************************
	always_comb
	begin
		burst_next = burst_reg;
		burst_wr_next = burst_wr_reg;
		order_next = order_reg;
		base_next = base_reg;
		cnt_next = cnt_reg;
		s1_valid_next = s1_valid_reg;
		s1_wr_next = s1_wr_reg;
		s1_addr_next = s1_addr_reg;
		s1_bw_next = s1_bw_reg;
		if (active)
		begin
			if (!advance_load_select)
			begin
				// Load ends any burst; a deselect loads an empty slot
				burst_next = selected;
				burst_wr_next = ~rw_select;
				order_next = burst_order_select ? PBS_INTERLEAVED : PBS_LINEAR;
				base_next = address;
				cnt_next = PBS_CNT_RST;
				s1_valid_next = selected;
				s1_wr_next = ~rw_select;
				s1_addr_next = address;
				s1_bw_next = ~byte_write_enables_n;
			end
			else
			begin
				// Continue: rw_select is not looked at here
				cnt_next = beat_cnt;
				s1_valid_next = burst_reg;
				s1_wr_next = burst_wr_reg;
				s1_addr_next = {base_reg[PBS_ADDR_W-1:PBS_BURST_W], beat_low};
				s1_bw_next = ~byte_write_enables_n;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			burst_reg <= 1'b0;
			burst_wr_reg <= 1'b0;
			order_reg <= PBS_LINEAR;
			base_reg <= PBS_ADDR_RST;
			cnt_reg <= PBS_CNT_RST;
			s1_valid_reg <= 1'b0;
			s1_wr_reg <= 1'b0;
			s1_addr_reg <= PBS_ADDR_RST;
			s1_bw_reg <= ~PBS_BW_OFF;
		end
		else
		begin
			burst_reg <= burst_next;
			burst_wr_reg <= burst_wr_next;
			order_reg <= order_next;
			base_reg <= base_next;
			cnt_reg <= cnt_next;
			s1_valid_reg <= s1_valid_next;
			s1_wr_reg <= s1_wr_next;
			s1_addr_reg <= s1_addr_next;
			s1_bw_reg <= s1_bw_next;
		end
	end

	// ****************************************
	// Second stage, storage and data bus
	// ****************************************
	// Lane merge; unwritten lanes keep their stored value
	genvar g;
	generate
		for (g = 0; g < PBS_LANES; g++)
		begin : g_lane
			assign wdata[g*PBS_LANE_W +: PBS_LANE_W] = s2_bw_reg[g] ? data_in[g*PBS_LANE_W +: PBS_LANE_W]
				: mem_reg[s2_addr_reg][g*PBS_LANE_W +: PBS_LANE_W];
		end
	endgenerate

	// Pipeline drains even after a deselect, since only stage one is emptied
	always_comb
	begin
		s2_valid_next = s2_valid_reg;
		s2_wr_next = s2_wr_reg;
		s2_addr_next = s2_addr_reg;
		s2_bw_next = s2_bw_reg;
		dout_next = dout_reg;
		oe_n_next = oe_n_reg;
		mem_we = 1'b0;
		if (active)
		begin
			s2_valid_next = s1_valid_reg;
			s2_wr_next = s1_wr_reg;
			s2_addr_next = s1_addr_reg;
			s2_bw_next = s1_bw_reg;
			mem_we = s2_valid_reg & s2_wr_reg;
			oe_n_next = ~(s2_valid_reg & ~s2_wr_reg);
			if (s2_valid_reg && !s2_wr_reg)
				dout_next = mem_reg[s2_addr_reg];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			s2_valid_reg <= 1'b0;
			s2_wr_reg <= 1'b0;
			s2_addr_reg <= PBS_ADDR_RST;
			s2_bw_reg <= ~PBS_BW_OFF;
			dout_reg <= PBS_DATA_RST;
			oe_n_reg <= 1'b1;
		end
		else
		begin
			s2_valid_reg <= s2_valid_next;
			s2_wr_reg <= s2_wr_next;
			s2_addr_reg <= s2_addr_next;
			s2_bw_reg <= s2_bw_next;
			dout_reg <= dout_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// Storage has no reset: contents are undefined after power-up, as in a real array
	always_ff @(posedge clock)
	begin
		if (mem_we)
			mem_reg[s2_addr_reg] <= wdata;
	end

	assign data_out = dout_reg;
	assign data_oe_n = oe_n_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_load_ends_burst: assert property (active && !advance_load_select && !selected |=> !burst_reg && !s1_valid_reg)
		else $error("Deselect load did not end the burst");
	a_rw_ignored: assert property (active && advance_load_select && burst_reg |=> s1_wr_reg == $past(burst_wr_reg))
		else $error("Burst beat direction followed the read/write pin");
	a_dir_latched: assert property (active && !advance_load_select && selected |=> burst_wr_reg == !$past(rw_select))
		else $error("Burst direction not latched at load");
	a_write_start: assert property (active && !advance_load_select && selected && !rw_select |=> s1_valid_reg && s1_wr_reg)
		else $error("Write not started on low read/write select");
	// Mask reaches stage two only after two active edges, so the check lands one cycle after both
	a_mask_delay: assert property (active ##1 active |=> s2_bw_reg == ~$past(byte_write_enables_n, 2))
		else $error("Byte mask not carried two cycles to the data");
	a_linear_order: assert property (active && advance_load_select && order_reg == PBS_LINEAR
		|=> s1_addr_reg[1:0] == 2'($past(base_reg[1:0]) + $past(cnt_reg) + 2'h1))
		else $error("Linear burst order wrong");
	a_inter_order: assert property (active && advance_load_select && order_reg == PBS_INTERLEAVED
		|=> s1_addr_reg[1:0] == ($past(base_reg[1:0]) ^ 2'($past(cnt_reg) + 2'h1)))
		else $error("Interleaved burst order wrong");
	a_select_pair: assert property (active && !advance_load_select && !chip_select_pair |=> !s1_valid_reg)
		else $error("Selected with pair enable low");
	a_drain_deselect: assert property (active && !advance_load_select && !selected && s1_valid_reg && !s1_wr_reg
		##1 active |=> !data_oe_n)
		else $error("Pending read lost after deselect");
	a_suspend_hold: assert property (!active |=> $stable(s1_addr_reg) && $stable(s2_valid_reg) && $stable(cnt_reg)
		&& $stable(data_oe_n))
		else $error("Register changed while suspended");
	a_read_latency: assert property (active && !advance_load_select && selected && rw_select ##1 active ##1 active
		|=> !data_oe_n)
		else $error("Read data not driven two cycles after address");

	c_read_burst: cover property (active && !advance_load_select && selected && rw_select ##1 (active && advance_load_select) [*3]);
	c_write_burst: cover property (active && !advance_load_select && selected && !rw_select ##1 (active && advance_load_select) [*3]);
	c_suspend: cover property (s1_valid_reg && !active ##1 active);
	c_read_to_deselect: cover property (!data_oe_n ##1 data_oe_n);

endmodule

// ===== pbs_pkg.sv
// Constants and types shared by the pipelined burst SRAM port
// Contract
// - Sampling advance/load low ends any burst and loads new address and control.
// - Read/write select is ignored while advance/load is high during a burst.
// - Direction is latched at the load cycle and kept for every burst beat.
// - Read/write select sampled low at a load cycle starts a write.
// - Byte enables sampled at address cycle; write data captured two cycles later.
// - A burst advances only the two lowest address bits over four words.
// - Selected only with both low-active enables low and the pair enable high.
// - A loaded deselect still completes transfers already in the pipeline.
// - Inactive clock enable holds every internal register as if no edge occurred.
package pbs_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int PBS_ADDR_W = 17;
	localparam int PBS_DATA_W = 36;
	localparam int PBS_LANES = 4;
	localparam int PBS_LANE_W = 9;
	localparam int PBS_DEPTH = 131072;
	localparam int PBS_BURST_W = 2;

	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [PBS_BURST_W-1:0] PBS_CNT_RST = 2'h0;
	localparam logic [PBS_BURST_W-1:0] PBS_CNT_STEP = 2'h1;
	localparam logic [PBS_ADDR_W-1:0] PBS_ADDR_RST = 17'h0_0000;
	localparam logic [PBS_LANES-1:0] PBS_BW_OFF = 4'hF;
	localparam logic [PBS_DATA_W-1:0] PBS_DATA_RST = 36'h0_0000_0000;

	// Burst order as chosen by the order select pin
	typedef enum logic {PBS_LINEAR, PBS_INTERLEAVED} pbs_order_e;

endpackage

// ===== pbs_host_model.sv
// Controller-side model that supplies write data two active cycles after the address cycle
`timescale 1ns/1ps
module pbs_host_model
	import pbs_pkg::*;
(
	// Clock and suspend pin
	input wire logic clock,
	input wire logic clock_enable_n,
	// Write beat announced at its address cycle
	input wire logic wr_beat,
	input wire logic [PBS_DATA_W-1:0] wr_data,
	// Data toward the port
	output logic [PBS_DATA_W-1:0] data_in
);
	logic pend_reg;
	logic [PBS_DATA_W-1:0] pend_data_reg;
	// ****************************************
	// Write data slot
	// ****************************************
	initial
	begin
		pend_reg = 1'b0;
		pend_data_reg = PBS_DATA_RST;
		data_in = PBS_DATA_RST;
	end
	// Idle slots show the inverse of the last value, so stale data never passes as valid
	always @(posedge clock)
	begin
		if (!clock_enable_n)
		begin
			pend_reg <= wr_beat;
			pend_data_reg <= wr_data;
			data_in <= pend_reg ? pend_data_reg : ~data_in;
		end
	end
endmodule

// ===== pipelined_burst_sram_port_tb.sv
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb
	import pbs_pkg::*;
;
	localparam logic [PBS_ADDR_W-1:0] AX = 17'h1_FFFF;
	localparam logic [PBS_DATA_W-1:0] MX = 36'hF_0803_0E00;
	logic clock, rst_b, advance_load_select, rw_select, burst_order_select, clock_enable_n, data_oe_n;
	logic chip_select_low_a_n, chip_select_low_b_n, chip_select_pair, wr_beat, exp_rd, act;
	logic [PBS_ADDR_W-1:0] address;
	logic [PBS_LANES-1:0] byte_write_enables_n;
	logic [PBS_DATA_W-1:0] data_in, data_out, wr_data, exp_d, a_d, b_d, c_d, last_q;
	logic a_rd, b_rd, c_rd, ord_v, cen_v;
	logic [2:0] cs_v;
	int n_errors, check_count;
	pbs_sram_port pbs_sram_port_inst (.clock(clock), .rst_b(rst_b), .address(address),
		.advance_load_select(advance_load_select), .rw_select(rw_select),
		.byte_write_enables_n(byte_write_enables_n), .burst_order_select(burst_order_select),
		.chip_select_low_a_n(chip_select_low_a_n), .chip_select_low_b_n(chip_select_low_b_n),
		.chip_select_pair(chip_select_pair), .clock_enable_n(clock_enable_n), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n));
	pbs_host_model pbs_host_model_inst (.clock(clock), .clock_enable_n(clock_enable_n),
		.wr_beat(wr_beat), .wr_data(wr_data), .data_in(data_in));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [PBS_DATA_W-1:0] seen, input logic [PBS_DATA_W-1:0] want);
		check_count++;
		if (seen !== want)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [PBS_DATA_W-1:0] dv(input int k);
		return 36'h5_5555_0000 + 36'(k);
	endfunction
	// One beat; k is 0 for none, 1 for an expected read, 2 for a write
	task automatic beat(input logic al, input logic rw, input logic [PBS_ADDR_W-1:0] a,
		input logic [PBS_LANES-1:0] bw, input logic [1:0] k, input logic [PBS_DATA_W-1:0] d);
		@(posedge clock);
		advance_load_select <= al;
		rw_select <= rw;
		address <= a;
		byte_write_enables_n <= bw;
		{chip_select_low_a_n, chip_select_low_b_n, chip_select_pair} <= cs_v;
		clock_enable_n <= cen_v;
		burst_order_select <= ord_v;
		wr_beat <= (k == 2'd2);
		wr_data <= d;
		exp_rd <= (k == 2'd1);
		exp_d <= d;
	endtask
	// Deselected loads keep the pipe empty
	task automatic idle(input int n);
		cs_v = 3'b000;
		repeat (n) beat(1'b0, 1'b1, AX, 4'hF, 2'd0, dv(0));
		cs_v = 3'b001;
	endtask
	// Outputs must follow the beat taken two active edges before, and hold on suspended edges
	always @(posedge clock)
	begin
		act = !clock_enable_n;
		if (rst_b && act)
		begin
			{c_rd, c_d} = {b_rd, b_d};
			{b_rd, b_d} = {a_rd, a_d};
			{a_rd, a_d} = {exp_rd, exp_d};
		end
		#1;
		if (rst_b)
		begin
			check({35'h0, data_oe_n}, {35'h0, !c_rd});
			if (c_rd) check(data_out, c_d);
			if (!act) check(data_out, last_q);
		end
		last_q = data_out;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_burst();
		beat(1'b0, 1'b0, 17'h0_0011, 4'h0, 2'd2, dv(0));
		for (int i = 1; i < 4; i++) beat(1'b1, 1'b1, AX, 4'h0, 2'd2, dv(i));
		idle(2);
		ord_v = 1'b1;
		beat(1'b0, 1'b1, 17'h0_0011, 4'hF, 2'd1, dv(0));
		beat(1'b1, 1'b0, AX, 4'hF, 2'd1, dv(3));
		beat(1'b1, 1'b0, AX, 4'hF, 2'd1, dv(2));
		beat(1'b1, 1'b0, AX, 4'hF, 2'd1, dv(1));
		idle(3);
		$display("burst order test done");
	endtask
	task automatic t_stall();
		beat(1'b0, 1'b1, 17'h0_0011, 4'hF, 2'd1, dv(0));
		ord_v = 1'b0;
		beat(1'b0, 1'b1, 17'h0_0013, 4'hF, 2'd1, dv(2));
		cen_v = 1'b1;
		repeat (2) beat(1'b0, 1'b0, AX, 4'h0, 2'd0, dv(9));
		cen_v = 1'b0;
		beat(1'b1, 1'b0, AX, 4'hF, 2'd1, dv(3));
		beat(1'b1, 1'b1, AX, 4'hF, 2'd1, dv(0));
		beat(1'b1, 1'b1, AX, 4'hF, 2'd1, dv(1));
		idle(3);
		$display("reload and suspend test done");
	endtask
	task automatic t_mask();
		beat(1'b0, 1'b0, 17'h0_0020, 4'h0, 2'd2, 36'hF_0F0F_0F0F);
		beat(1'b0, 1'b0, 17'h0_0020, 4'hA, 2'd2, 36'h0_0000_0000);
		idle(2);
		beat(1'b0, 1'b1, 17'h0_0020, 4'hF, 2'd1, MX);
		idle(3);
		$display("byte mask test done");
	endtask
	task automatic t_desel();
		logic [2:0] pat [3] = '{3'b101, 3'b011, 3'b000};
		for (int i = 0; i < 3; i++)
		begin
			beat(1'b0, 1'b1, 17'h0_0020, 4'hF, 2'd1, MX);
			cs_v = pat[i];
			beat(1'b0, 1'b0, 17'h0_0020, 4'h0, 2'd0, dv(0));
			cs_v = 3'b001;
			beat(1'b1, 1'b1, AX, 4'h0, 2'd0, dv(0));
		end
		beat(1'b0, 1'b1, 17'h0_0020, 4'hF, 2'd1, MX);
		idle(3);
		$display("deselect test done");
	endtask
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		{rst_b, advance_load_select, rw_select, burst_order_select, clock_enable_n} = 5'b00100;
		{chip_select_low_a_n, chip_select_low_b_n, chip_select_pair, wr_beat, exp_rd} = 5'b11000;
		{address, byte_write_enables_n, wr_data, exp_d} = '0;
		{a_rd, b_rd, c_rd, ord_v, cen_v, cs_v} = 8'h01;
		{a_d, b_d, c_d, last_q} = '0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		check({35'h0, data_oe_n}, 36'h0_0000_0001);
		check(data_out, PBS_DATA_RST);
		t_burst();
		t_stall();
		t_mask();
		t_desel();
		report_and_stop();
	end
	// Watchdog well beyond the roughly fifty cycles the tests need
	initial
	begin
		#16000;
		n_errors++;
		report_and_stop();
	end
endmodule
